// ### rtl/maf_pkg.sv
// Package for the MAC address filter and pause countdown block
package maf_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int SLOTS = 4;
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFF_HASH_LOW = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_HASH_HIGH = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_SLOT_BASE = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_PAUSE = 8'h28;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h2c;
   localparam logic [ADDR_W-1:0] SLOT_STRIDE = 8'h08;
   localparam logic [ADDR_W-1:0] HIGH_STEP = 8'h04;
   // Field layout
   localparam int PAUSE_W = 16;
   localparam int STAT_PTZ_BIT = 0;
   localparam int STAT_PAUSED_BIT = 1;
   localparam int HIGH_W = 16;
   localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;
   localparam logic [PAUSE_W-1:0] PAUSE_ZERO = 16'h0000;
   localparam logic [PAUSE_W-1:0] PAUSE_ONE = 16'h0001;
   // One pause quantum is 512 bit times
   localparam int QUANTUM_BITS = 512;
   localparam int SLOW_BITS_PER_TICK = 1;
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic [2:0] HSIZE_WORD = 3'b010;

   typedef struct packed {
      logic [DATA_W-1:0] low;
      logic [HIGH_W-1:0] high;
   } maf_slot_s;

   typedef struct packed {
      logic valid;
      logic [47:0] dest;
   } maf_dest_s;
endpackage

// ### rtl/maf_quantum_timer.sv
// Pause quantum timer: counts link bit times and pulses every 512
`timescale 1ns/1ps
`default_nettype none
module maf_quantum_timer
   import maf_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Link bit-time strobe, already in mclk domain
   input wire logic bitTick,
   input wire logic run,
   // Quantum pulse
   output logic quantumPulse
);
   logic [9:0] bitCount_q;

   always_ff @(posedge mclk) begin
      if (!rst_b || !run) begin
         bitCount_q <= 10'h000;
         quantumPulse <= 1'b0;
      end else if (bitTick) begin
         if (bitCount_q == 10'(QUANTUM_BITS - 1)) begin
            bitCount_q <= 10'h000;
            quantumPulse <= 1'b1;
         end else begin
            bitCount_q <= bitCount_q + 10'h001;
            quantumPulse <= 1'b0;
         end
      end else begin
         quantumPulse <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### rtl/maf_regs.sv
// Address filter registers, pause countdown and AHB-Lite slave
// What this block does
// - Pause count drops by one every 512 bit times while pause is active.
// - Count reaching zero sets a flag; reading status clears it.
// - Hash filter low register, read/write, holds hash bits 31 to 0.
// - Hash filter high register, read/write, holds hash bits 63 to 32.
// - Each slot low register holds address bits 31 to 0, full read/write.
// - Slot low bit zero matches lsb of first received address byte.
// - Slot high register holds address bits 47 to 32; upper half unused.
`timescale 1ns/1ps
`default_nettype none
module maf_regs
   import maf_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [DATA_W-1:0] hwdata,
   output logic [DATA_W-1:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Link bit-time strobe, one per bit on the wire
   input wire logic linkBitTick,
   // Receive path destination address
   input wire maf_dest_s rxDest,
   // Filter outputs to the receive path
   output logic [63:0] hashFilter,
   output logic addrMatch,
   output logic [SLOTS-1:0] slotHit,
   output logic pauseActive,
   output logic pauseZeroFlag
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_DATA = 2'b10
   } maf_bus_e;

   maf_bus_e busState_q;
   logic [ADDR_W-1:0] addr_q;
   logic write_q;
   logic [DATA_W-1:0] hashLow_q;
   logic [DATA_W-1:0] hashHigh_q;
   maf_slot_s [SLOTS-1:0] slot_q;
   logic [PAUSE_W-1:0] pauseCount_q;
   logic ptz_q;
   logic tickMeta_q;
   logic tickSync_q;
   logic tickPrev_q;
   logic bitStrobe;
   logic quantum;
   logic [SLOTS-1:0] hitNow;
   logic accept;
   logic wrData;
   logic rdStatus;
   logic pauseWrite;
   logic [DATA_W-1:0] rdWord;
   logic [PAUSE_W-1:0] pauseNext;
   logic ptzNext;
   logic zeroEvent;

   // Slot register offset helpers
   function automatic logic [ADDR_W-1:0] slotLowOff(input int i);
      slotLowOff = ADDR_W'(OFF_SLOT_BASE + ADDR_W'(i) * SLOT_STRIDE);
   endfunction

   function automatic logic [ADDR_W-1:0] slotHighOff(input int i);
      slotHighOff = ADDR_W'(slotLowOff(i) + HIGH_STEP);
   endfunction

   assign accept = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD);
   assign wrData = (busState_q == ST_DATA) && write_q;
   assign rdStatus = (busState_q == ST_DATA) && !write_q && (addr_q == OFF_STATUS);
   assign pauseWrite = wrData && (addr_q == OFF_PAUSE);

   // Bus phase tracking, zero wait states
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         busState_q <= ST_IDLE;
         addr_q <= '0;
         write_q <= 1'b0;
      end else begin
         case (busState_q)
            ST_IDLE: begin
               if (accept) begin
                  busState_q <= ST_DATA;
                  addr_q <= haddr;
                  write_q <= hwrite;
               end
            end
            ST_DATA: begin
               if (accept) begin
                  addr_q <= haddr;
                  write_q <= hwrite;
               end else begin
                  busState_q <= ST_IDLE;
               end
            end
            default: busState_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         hashLow_q <= RESET_WORD;
      end else if (wrData && addr_q == OFF_HASH_LOW) begin
         hashLow_q <= hwdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         hashHigh_q <= RESET_WORD;
      end else if (wrData && addr_q == OFF_HASH_HIGH) begin
         hashHigh_q <= hwdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         slot_q <= '0;
      end else begin
         for (int i = 0; i < SLOTS; i++) begin
            if (wrData && addr_q == slotLowOff(i)) begin
               slot_q[i].low <= hwdata;
            end
            if (wrData && addr_q == slotHighOff(i)) begin
               slot_q[i].high <= hwdata[HIGH_W-1:0];
            end
         end
      end
   end

   // Two-flop sync of the link bit strobe, then edge detect
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         tickMeta_q <= 1'b0;
         tickSync_q <= 1'b0;
         tickPrev_q <= 1'b0;
      end else begin
         tickMeta_q <= linkBitTick;
         tickSync_q <= tickMeta_q;
         tickPrev_q <= tickSync_q;
      end
   end

   assign bitStrobe = tickSync_q && !tickPrev_q;

   maf_quantum_timer u_timer (
      .mclk(mclk),
      .rst_b(rst_b),
      .bitTick(bitStrobe),
      .run(pauseCount_q != PAUSE_ZERO),
      .quantumPulse(quantum)
   );

   always_comb begin
      pauseNext = pauseCount_q;
      if (pauseWrite) begin
         pauseNext = hwdata[PAUSE_W-1:0];
      end else if (quantum && pauseCount_q != PAUSE_ZERO) begin
         pauseNext = pauseCount_q - PAUSE_ONE;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         pauseCount_q <= PAUSE_ZERO;
      end else begin
         pauseCount_q <= pauseNext;
      end
   end

   // zero flag, set wins over read clear
   assign zeroEvent = !pauseWrite && quantum && pauseCount_q == PAUSE_ONE;

   always_comb begin
      ptzNext = ptz_q;
      if (zeroEvent) begin
         ptzNext = 1'b1;
      end else if (rdStatus) begin
         ptzNext = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         ptz_q <= 1'b0;
      end else begin
         ptz_q <= ptzNext;
      end
   end

   maf_slot_match u_match (
      .slots(slot_q),
      .dest(rxDest),
      .hit(hitNow)
   );

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         slotHit <= '0;
         addrMatch <= 1'b0;
      end else begin
         slotHit <= hitNow;
         addrMatch <= |hitNow;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         hashFilter <= '0;
         pauseActive <= 1'b0;
         pauseZeroFlag <= 1'b0;
      end else begin
         hashFilter <= {hashHigh_q, hashLow_q};
         pauseActive <= (pauseCount_q != PAUSE_ZERO);
         pauseZeroFlag <= ptz_q;
      end
   end

   // Read mux for the next data phase; unmapped reads return zero
   // A pipelined read sees what the edge leaves behind, not a stale word
   always_comb begin
      rdWord = RESET_WORD;
      if (haddr == OFF_HASH_LOW) begin
         rdWord = hashLow_q;
      end else if (haddr == OFF_HASH_HIGH) begin
         rdWord = hashHigh_q;
      end else if (haddr == OFF_PAUSE) begin
         rdWord = DATA_W'(pauseNext);
      end else if (haddr == OFF_STATUS) begin
         rdWord[STAT_PTZ_BIT] = ptzNext;
         rdWord[STAT_PAUSED_BIT] = (pauseNext != PAUSE_ZERO);
      end else begin
         for (int i = 0; i < SLOTS; i++) begin
            if (haddr == slotLowOff(i)) begin
               rdWord = slot_q[i].low;
            end
            if (haddr == slotHighOff(i)) begin
               rdWord = DATA_W'(slot_q[i].high);
            end
         end
      end
      // Forward a write data phase to a read of the same word
      if (wrData && addr_q == haddr) begin
         if (haddr == OFF_HASH_LOW || haddr == OFF_HASH_HIGH) begin
            rdWord = hwdata;
         end else begin
            for (int i = 0; i < SLOTS; i++) begin
               if (haddr == slotLowOff(i)) begin
                  rdWord = hwdata;
               end
               if (haddr == slotHighOff(i)) begin
                  rdWord = DATA_W'(hwdata[HIGH_W-1:0]);
               end
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         hrdata <= RESET_WORD;
      end else if (accept && !hwrite) begin
         hrdata <= rdWord;
      end
   end

   // Assertions
   pause_step_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (quantum && !pauseWrite && pauseCount_q != PAUSE_ZERO) |=> pauseCount_q == $past(pauseCount_q) - PAUSE_ONE)
      else $error("pause count did not step down");
   pause_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (!quantum && !pauseWrite) |=> $stable(pauseCount_q))
      else $error("pause count moved without a quantum");
   zero_flag_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (quantum && !pauseWrite && pauseCount_q == PAUSE_ONE) |=> ptz_q ##1 pauseZeroFlag)
      else $error("zero flag not raised");
   flag_clear_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (rdStatus && !(quantum && pauseCount_q == PAUSE_ONE)) |=> !ptz_q)
      else $error("zero flag not cleared by status read");
   hash_low_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (wrData && addr_q == OFF_HASH_LOW) |=> ##1 hashFilter[31:0] == $past(hwdata, 2))
      else $error("hash low not stored");
   hash_high_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (wrData && addr_q == OFF_HASH_HIGH) |=> ##1 hashFilter[63:32] == $past(hwdata, 2))
      else $error("hash high not stored");
   slot_low_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (wrData && addr_q == OFF_SLOT_BASE) |=> slot_q[0].low == $past(hwdata))
      else $error("slot low not stored");
   slot_high_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (accept && !hwrite && haddr == slotHighOff(0)) |=> hrdata[DATA_W-1:HIGH_W] == '0)
      else $error("slot high upper half not zero");
   match_any_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (rxDest.valid && rxDest.dest == {slot_q[1].high, slot_q[1].low}) |=> addrMatch && slotHit[1])
      else $error("slot match missed");
   mcast_bit_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (rxDest.valid && rxDest.dest[0] != slot_q[2].low[0]) |=> !slotHit[2])
      else $error("multicast bit ignored");
   pause_load_a: assert property (@(posedge mclk) disable iff (!rst_b)
      pauseWrite |=> pauseCount_q == PAUSE_W'($past(hwdata)))
      else $error("pause count write not taken");
   zero_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (ptz_q && !rdStatus) |=> ptz_q)
      else $error("zero flag lost without a status read");
   flag_cause_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (!ptz_q && !zeroEvent) |=> !ptz_q)
      else $error("zero flag set without reaching zero");
   status_view_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (accept && !hwrite && haddr == OFF_STATUS) |=> hrdata[STAT_PAUSED_BIT] == (pauseCount_q != PAUSE_ZERO))
      else $error("status paused bit disagrees with count");
   hash_read_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (accept && !hwrite && haddr == OFF_HASH_LOW) |=> hrdata == hashLow_q)
      else $error("hash low read mismatch");
   hash_top_read_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (accept && !hwrite && haddr == OFF_HASH_HIGH) |=> hrdata == hashHigh_q)
      else $error("hash high read mismatch");
   slot_read_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (accept && !hwrite && haddr == slotLowOff(3)) |=> hrdata == slot_q[3].low)
      else $error("slot low read mismatch");
   match_none_a: assert property (@(posedge mclk) disable iff (!rst_b)
      !rxDest.valid |=> !addrMatch)
      else $error("match raised without a valid address");
endmodule
`default_nettype wire

// ### rtl/maf_slot_match.sv
// Compare a received destination address against the four slots
`timescale 1ns/1ps
`default_nettype none
module maf_slot_match
   import maf_pkg::*;
(
   // Programmed slots
   input wire maf_slot_s [SLOTS-1:0] slots,
   // Received destination address, first byte in bits 7:0
   input wire maf_dest_s dest,
   // Match result
   output logic [SLOTS-1:0] hit
);
   // bit zero compares with first byte lsb
   always_comb begin
      for (int i = 0; i < SLOTS; i++) begin
         hit[i] = dest.valid && (dest.dest == {slots[i].high, slots[i].low});
      end
   end
endmodule
`default_nettype wire

// ### verification/maf_phy_model.sv
// Far-side link model: makes the bit-time strobe seen on the wire
`timescale 1ns/1ps
`default_nettype none
module maf_phy_model
   import maf_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Link active while a frame is on the wire
   input wire logic run,
   // Bit-time strobe, two mclk high and two low
   output logic linkBitTick
);
   logic phase_q;

   // Strobe stands still low outside frames
   always_ff @(posedge mclk) begin
      if (!rst_b || !run) begin
         phase_q <= 1'b0;
         linkBitTick <= 1'b0;
      end else begin
         phase_q <= ~phase_q;
         if (phase_q) begin
            linkBitTick <= ~linkBitTick;
         end
      end
   end
endmodule
`default_nettype wire

// ### verification/test_maf_regs.sv
// Self-checking bench for the address filter register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin numErrors++; \
   $display("FAIL t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_maf_regs
   import maf_pkg::*;
;
   logic mclk;
   logic rst_b;
   logic hsel;
   logic hwrite;
   logic run;
   logic [ADDR_W-1:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [DATA_W-1:0] hwdata;
   logic [DATA_W-1:0] hrdata;
   logic [DATA_W-1:0] rdv;
   logic hreadyout;
   logic hresp;
   logic linkBitTick;
   logic addrMatch;
   logic pauseActive;
   logic pauseZeroFlag;
   maf_dest_s rxDest;
   logic [63:0] hashFilter;
   logic [SLOTS-1:0] slotHit;
   int numErrors = 0;
   int comparisons = 0;

   maf_regs dut (.mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .linkBitTick(linkBitTick), .rxDest(rxDest),
      .hashFilter(hashFilter), .addrMatch(addrMatch), .slotHit(slotHit),
      .pauseActive(pauseActive), .pauseZeroFlag(pauseZeroFlag));

   maf_phy_model phy (.mclk(mclk), .rst_b(rst_b), .run(run), .linkBitTick(linkBitTick));

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   task automatic conclude();
      if (numErrors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // One single AHB-Lite word transfer; read data left in rdv
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge mclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= HTRANS_NONSEQ;
      hsize <= HSIZE_WORD;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rdv = hrdata;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      xfer(1'b0, a, 32'h0000_0000);
      `CHK(rdv, exp)
      `CHK(hresp, 1'b0)
   endtask

   // Present a destination address and check the registered match result
   task automatic match(input logic [47:0] d, input logic [SLOTS-1:0] h);
      @(posedge mclk);
      rxDest <= '{valid: 1'b1, dest: d};
      repeat (2) @(posedge mclk);
      `CHK(slotHit, h)
      `CHK(addrMatch, |h)
   endtask

   initial begin
      rst_b = 1'b0;
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = HSIZE_WORD;
      hwdata = 32'h0000_0000;
      run = 1'b0;
      rxDest = '{valid: 1'b0, dest: 48'h5555_aaaa_5555};
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      // Every mapped word resets to zero; 0x30 is unmapped
      for (int a = 0; a <= 'h30; a += 4) begin
         rd(8'(a), RESET_WORD);
      end
      xfer(1'b1, 8'h30, 32'hffff_ffff);
      rd(8'h30, 32'h0000_0000);
      xfer(1'b1, OFF_HASH_LOW, 32'hdead_beef);
      xfer(1'b1, OFF_HASH_HIGH, 32'h0123_4567);
      rd(OFF_HASH_LOW, 32'hdead_beef);
      rd(OFF_HASH_HIGH, 32'h0123_4567);
      `CHK(hashFilter, 64'h0123_4567_dead_beef)
      // Odd slots carry the multicast bit set
      for (int i = 0; i < SLOTS; i++) begin
         xfer(1'b1, OFF_SLOT_BASE + 8'(8 * i), 32'h1234_5670 + 32'(i));
         xfer(1'b1, OFF_SLOT_BASE + 8'(8 * i) + HIGH_STEP, 32'hffff_a000 + 32'(i));
      end
      for (int i = 0; i < SLOTS; i++) begin
         rd(OFF_SLOT_BASE + 8'(8 * i), 32'h1234_5670 + 32'(i));
         rd(OFF_SLOT_BASE + 8'(8 * i) + HIGH_STEP, 32'h0000_a000 + 32'(i));
         match({16'ha000 + 16'(i), 32'h1234_5670 + 32'(i)}, 4'(1 << i));
         match({16'ha000 + 16'(i), 32'h1234_5671 ^ 32'(i)}, 4'h0);
      end
      // A matching address without valid must not hit
      @(posedge mclk);
      rxDest <= '{valid: 1'b0, dest: {16'ha000, 32'h1234_5670}};
      repeat (2) @(posedge mclk);
      `CHK(addrMatch, 1'b0)
      `CHK(slotHit, 4'h0)
      xfer(1'b1, OFF_PAUSE, 32'h0000_0002);
      run <= 1'b1;
      repeat (1000) @(posedge mclk);
      rd(OFF_PAUSE, 32'h0000_0002);
      rd(OFF_STATUS, 32'h0000_0002);
      `CHK(pauseActive, 1'b1)
      repeat (2000) @(posedge mclk);
      rd(OFF_PAUSE, 32'h0000_0001);
      repeat (2500) @(posedge mclk);
      rd(OFF_PAUSE, 32'h0000_0000);
      `CHK(pauseActive, 1'b0)
      `CHK(pauseZeroFlag, 1'b1)
      rd(OFF_STATUS, 32'h0000_0001);
      rd(OFF_STATUS, 32'h0000_0000);
      `CHK(pauseZeroFlag, 1'b0)
      run <= 1'b0;
      conclude();
   end

   initial begin
      repeat (20000) @(posedge mclk);
      numErrors++;
      conclude();
   end
endmodule
`default_nettype wire
